// ==== design/afr_defines.svh ====
// Register offsets, field positions, reset values of the flag/result block
`ifndef AFR_DEFINES_SVH
`define AFR_DEFINES_SVH

// Register offsets (byte addresses)
`define AFR_BUF_LAST      8'h13
`define AFR_CSR           8'h20
`define AFR_CR1           8'h21
`define AFR_CR2           8'h22
`define AFR_CR3           8'h23
`define AFR_RES_HI        8'h24
`define AFR_RES_LO        8'h25
`define AFR_TDR_HI        8'h26
`define AFR_TDR_LO        8'h27
`define AFR_UTH_HI        8'h28
`define AFR_UTH_LO        8'h29
`define AFR_LTH_HI        8'h2A
`define AFR_LTH_LO        8'h2B
`define AFR_AWS_HI        8'h2C
`define AFR_AWS_LO        8'h2D
`define AFR_AWEN_HI       8'h2E
`define AFR_AWEN_LO       8'h2F

// Field positions
`define AFR_CSR_EOC       7
`define AFR_CSR_AWD       6
`define AFR_CSR_CONV_DONE_IRQ_ENABLE     5
`define AFR_CSR_WATCHDOG_IRQ_ENABLE     4
`define AFR_CR1_CONT      1
`define AFR_CR1_ADON      0
`define AFR_CR2_ALIGN     3
`define AFR_CR2_SCAN      1
`define AFR_CR3_DBUF      7
`define AFR_CR3_OVR       6

// Sizes and reset values
`define AFR_DEPTH         10
`define AFR_RES_W         10
`define AFR_RST_BYTE      8'h00
`define AFR_RST_THR_HI    10'h3FF
`define AFR_RST_THR_LO    10'h000
`define AFR_ALIGN_LEFT    1'b0
`define AFR_ALIGN_RIGHT   1'b1

`endif

// ==== design/afr_pkg.sv ====
// Types shared by the flag/result block
`default_nettype none
package afr_pkg;

    // Operating mode of the converter sequencer
    typedef enum logic [1:0] {
        MODE_SINGLE   = 2'b00,
        MODE_CONT     = 2'b01,
        MODE_BUFFERED = 2'b10,
        MODE_SCAN     = 2'b11
    } afr_mode_e;

    // One finished conversion from the analog core
    typedef struct packed {
        logic       valid;
        logic [3:0] index;
        logic [9:0] data;
    } afr_conv_s;

endpackage : afr_pkg
`default_nettype wire

// ==== design/afr_align.sv ====
// Splits a 10-bit result into high and low bytes by alignment
`timescale 1ns/1ns
`default_nettype none
`include "afr_defines.svh"

module afr_align (
    input  wire logic [9:0] data,
    input  wire logic       right,
    output logic      [7:0] hi_byte,
    output logic      [7:0] lo_byte
);

    // Right: low 8 bits in low byte; left: top 8 bits in high byte
    always_comb begin
        if (right == `AFR_ALIGN_RIGHT) begin
            hi_byte = {6'h00, data[9:8]};
            lo_byte = data[7:0];
        end else begin
            hi_byte = data[9:2];
            lo_byte = {data[1:0], 6'h00};
        end
    end

endmodule : afr_align
`default_nettype wire

// ==== design/afr_window.sv ====
// Watchdog window compare of a result against two thresholds
`timescale 1ns/1ns
`default_nettype none

module afr_window (
    input  wire logic [9:0] data,
    input  wire logic [9:0] upper,
    input  wire logic [9:0] lower,
    output logic            outside
);

    // Outside when above the upper or below the lower threshold
    assign outside = (data > upper) || (data < lower);

endmodule : afr_window
`default_nettype wire

// ==== design/afr_flag_result.sv ====
// Flags, interrupt, watchdog and result alignment of the converter
`timescale 1ns/1ns
`default_nettype none
`include "afr_defines.svh"

module afr_flag_result (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic [7:0]         bus_addr,
    input  wire logic [7:0]         bus_wdata,
    input  wire logic               bus_wr,
    input  wire logic               bus_rd,
    output logic      [7:0]         bus_rdata,
    input  wire afr_pkg::afr_conv_s conv_in,
    input  wire logic               seq_end,
    output logic                    conv_stop,
    output logic                    irq,
    output logic                    wake_from_wait,
    output logic                    conv_on,
    output logic                    conv_cont,
    output logic                    conv_scan,
    output logic                    conv_dbuf,
    output logic      [3:0]         conv_channel,
    output logic      [15:0]        schmitt_off
);

    ////////////////////////////////////////////////////////////////////////
    // State

    logic       eoc_r,   eoc_nxt;
    logic       awd_r,   awd_nxt;
    logic       conv_done_irq_enable_r, conv_done_irq_enable_nxt;
    logic       watchdog_irq_enable_r, watchdog_irq_enable_nxt;
    logic [3:0] ch_r,    ch_nxt;
    logic [2:0] spsel_r, spsel_nxt;
    logic       cont_r,  cont_nxt;
    logic       adon_r,  adon_nxt;
    logic [2:0] trig_r,  trig_nxt;
    logic       align_r, align_nxt;
    logic       scan_r,  scan_nxt;
    logic       dbuf_r,  dbuf_nxt;
    logic       ovr_r,   ovr_nxt;
    logic [15:0] tdr_r,  tdr_nxt;
    logic [9:0] uth_r,   uth_nxt;
    logic [9:0] lth_r,   lth_nxt;
    logic [9:0] aws_r,   aws_nxt;
    logic [9:0] awen_r,  awen_nxt;
    logic [7:0] res_hi_r, res_hi_nxt;
    logic [7:0] res_lo_r, res_lo_nxt;
    logic [7:0] hold_r,  hold_nxt;
    logic       hold_v_r, hold_v_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic       stop_r,  stop_nxt;
    logic       irq_r,   irq_nxt;
    logic [9:0] buf_mem [`AFR_DEPTH];

    afr_pkg::afr_mode_e mode;
    logic       multi;
    logic       outside;
    logic       both_ie;
    logic [9:0] aws_new;
    logic [7:0] cv_hi, cv_lo, bf_hi, bf_lo;
    logic [3:0] bidx;
    logic       wr_csr;

    // Register write hit on a given offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    // One-hot watchdog bit for a valid slot index
    function automatic logic [9:0] slot(input logic [3:0] i);
        slot = (i < 4'(`AFR_DEPTH)) ? (10'h001 << i) : 10'h000;
    endfunction : slot

    ////////////////////////////////////////////////////////////////////////
    // Mode decode and helpers

    always_comb begin
        if (scan_r)
            mode = afr_pkg::MODE_SCAN;
        else if (dbuf_r && cont_r)
            mode = afr_pkg::MODE_BUFFERED;
        else if (cont_r)
            mode = afr_pkg::MODE_CONT;
        else
            mode = afr_pkg::MODE_SINGLE;
    end

    // Buffered and scan share the sequence-based flag behaviour
    assign multi   = (mode == afr_pkg::MODE_SCAN) ||
                     (mode == afr_pkg::MODE_BUFFERED);
    assign both_ie = watchdog_irq_enable_r && conv_done_irq_enable_r;
    assign wr_csr  = bus_wr && hit(bus_addr, `AFR_CSR);
    assign bidx    = bus_addr[4:1];

    afr_window u_window (
        .data    (conv_in.data),
        .upper   (uth_r),
        .lower   (lth_r),
        .outside (outside)
    );

    afr_align u_conv_align (
        .data    (conv_in.data),
        .right   (align_r),
        .hi_byte (cv_hi),
        .lo_byte (cv_lo)
    );

    // Buffer entries keep raw data and are formatted when read
    afr_align u_buf_align (
        .data    (buf_mem[(bidx < 4'(`AFR_DEPTH)) ? bidx : 4'h0]),
        .right   (align_r),
        .hi_byte (bf_hi),
        .lo_byte (bf_lo)
    );

    // per-slot watchdog status set on excursion
    assign aws_new = (conv_in.valid && multi && outside) ?
                     (slot(conv_in.index) & awen_r) : 10'h000;

    ////////////////////////////////////////////////////////////////////////
    // Flags and control registers

    always_comb begin
        conv_done_irq_enable_nxt = conv_done_irq_enable_r;
        watchdog_irq_enable_nxt = watchdog_irq_enable_r;
        ch_nxt    = ch_r;
        spsel_nxt = spsel_r;
        cont_nxt  = cont_r;
        adon_nxt  = adon_r;
        trig_nxt  = trig_r;
        align_nxt = align_r;
        scan_nxt  = scan_r;
        dbuf_nxt  = dbuf_r;
        tdr_nxt   = tdr_r;
        uth_nxt   = uth_r;
        lth_nxt   = lth_r;
        awen_nxt  = awen_r;
        eoc_nxt   = eoc_r;
        awd_nxt   = awd_r;
        ovr_nxt   = ovr_r;
        aws_nxt   = aws_r;
        stop_nxt  = 1'b0;
        // Software side: flags only clear on a written 0
        if (bus_wr) begin
            unique case (bus_addr)
                `AFR_CSR: begin
                    // write 0 clears, 1 is ignored
                    eoc_nxt   = eoc_r & bus_wdata[`AFR_CSR_EOC];
                    awd_nxt   = awd_r & bus_wdata[`AFR_CSR_AWD];
                    conv_done_irq_enable_nxt = bus_wdata[`AFR_CSR_CONV_DONE_IRQ_ENABLE];
                    watchdog_irq_enable_nxt = bus_wdata[`AFR_CSR_WATCHDOG_IRQ_ENABLE];
                    ch_nxt    = bus_wdata[3:0];
                end
                `AFR_CR1: begin
                    spsel_nxt = bus_wdata[6:4];
                    cont_nxt  = bus_wdata[`AFR_CR1_CONT];
                    adon_nxt  = bus_wdata[`AFR_CR1_ADON];
                end
                `AFR_CR2: begin
                    trig_nxt  = bus_wdata[6:4];
                    align_nxt = bus_wdata[`AFR_CR2_ALIGN];
                    scan_nxt  = bus_wdata[`AFR_CR2_SCAN];
                end
                `AFR_CR3: begin
                    dbuf_nxt  = bus_wdata[`AFR_CR3_DBUF];
                    ovr_nxt   = ovr_r & bus_wdata[`AFR_CR3_OVR];
                end
                `AFR_TDR_HI:  tdr_nxt[15:8] = bus_wdata;
                `AFR_TDR_LO:  tdr_nxt[7:0]  = bus_wdata;
                `AFR_UTH_HI:  uth_nxt[9:2]  = bus_wdata;
                `AFR_UTH_LO:  uth_nxt[1:0]  = bus_wdata[1:0];
                `AFR_LTH_HI:  lth_nxt[9:2]  = bus_wdata;
                `AFR_LTH_LO:  lth_nxt[1:0]  = bus_wdata[1:0];
                `AFR_AWS_HI:  aws_nxt[9:8]  = aws_r[9:8] & bus_wdata[1:0];
                `AFR_AWS_LO:  aws_nxt[7:0]  = aws_r[7:0] & bus_wdata;
                `AFR_AWEN_HI: awen_nxt[9:8] = bus_wdata[1:0];
                `AFR_AWEN_LO: awen_nxt[7:0] = bus_wdata;
                default: ;
            endcase
        end
        // Hardware sets win over a same-cycle software clear
        aws_nxt = aws_nxt | aws_new;
        if (multi) begin
            // done flag once per buffer run or scan
            if (seq_end)
                eoc_nxt = 1'b1;
            // both enables: flag at once and stop
            if (both_ie && (aws_new != 10'h000)) begin
                awd_nxt  = 1'b1;
                stop_nxt = 1'b1;
            end
            if (!both_ie && seq_end && ((aws_r | aws_new) != 10'h000))
                awd_nxt = 1'b1;
            // Run completed again before software took the last one
            if (mode == afr_pkg::MODE_BUFFERED && seq_end && eoc_r)
                ovr_nxt = 1'b1;
        end else if (conv_in.valid) begin
            eoc_nxt = 1'b1;
            if (outside)
                awd_nxt = 1'b1;
        end
        // single request from either enabled flag
        irq_nxt = (eoc_nxt && conv_done_irq_enable_r) || (awd_nxt && watchdog_irq_enable_r);
    end

    // Reset values all zero except an open watchdog window
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            eoc_r   <= 1'b0;
            awd_r   <= 1'b0;
            conv_done_irq_enable_r <= 1'b0;
            watchdog_irq_enable_r <= 1'b0;
            ch_r    <= 4'h0;
            spsel_r <= 3'h0;
            cont_r  <= 1'b0;
            adon_r  <= 1'b0;
            trig_r  <= 3'h0;
            align_r <= `AFR_ALIGN_LEFT;
            scan_r  <= 1'b0;
            dbuf_r  <= 1'b0;
            ovr_r   <= 1'b0;
            tdr_r   <= 16'h0000;
            uth_r   <= `AFR_RST_THR_HI;
            lth_r   <= `AFR_RST_THR_LO;
            aws_r   <= 10'h000;
            awen_r  <= 10'h000;
            stop_r  <= 1'b0;
            irq_r   <= 1'b0;
        end else begin
            eoc_r   <= eoc_nxt;
            awd_r   <= awd_nxt;
            conv_done_irq_enable_r <= conv_done_irq_enable_nxt;
            watchdog_irq_enable_r <= watchdog_irq_enable_nxt;
            ch_r    <= ch_nxt;
            spsel_r <= spsel_nxt;
            cont_r  <= cont_nxt;
            adon_r  <= adon_nxt;
            trig_r  <= trig_nxt;
            align_r <= align_nxt;
            scan_r  <= scan_nxt;
            dbuf_r  <= dbuf_nxt;
            ovr_r   <= ovr_nxt;
            tdr_r   <= tdr_nxt;
            uth_r   <= uth_nxt;
            lth_r   <= lth_nxt;
            aws_r   <= aws_nxt;
            awen_r  <= awen_nxt;
            stop_r  <= stop_nxt;
            irq_r   <= irq_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data buffer: written per conversion in multi modes

    // no lock: an entry may change between its two byte reads
    always_ff @(posedge clk) begin
        if (conv_in.valid && multi && conv_in.index < 4'(`AFR_DEPTH))
            buf_mem[conv_in.index] <= conv_in.data;
    end

    ////////////////////////////////////////////////////////////////////////
    // Result pair and read path

    always_comb begin
        res_hi_nxt = res_hi_r;
        res_lo_nxt = res_lo_r;
        hold_nxt   = hold_r;
        hold_v_nxt = hold_v_r;
        rdata_nxt  = 8'h00;
        // every result lands in the pair
        if (conv_in.valid) begin
            res_hi_nxt = cv_hi;
            res_lo_nxt = cv_lo;
        end
        if (bus_rd) begin
            if (bus_addr <= `AFR_BUF_LAST)
                rdata_nxt = bus_addr[0] ? bf_lo : bf_hi;
            else begin
                unique case (bus_addr)
                    `AFR_CSR: rdata_nxt = {eoc_r, awd_r, conv_done_irq_enable_r,
                                           watchdog_irq_enable_r, ch_r};
                    `AFR_CR1: rdata_nxt = {1'b0, spsel_r, 2'b00,
                                           cont_r, adon_r};
                    `AFR_CR2: rdata_nxt = {1'b0, trig_r, align_r,
                                           1'b0, scan_r, 1'b0};
                    `AFR_CR3: rdata_nxt = {dbuf_r, ovr_r, 6'h00};
                    // reading the full byte first (low if right, high if left) freezes its partner
                    `AFR_RES_HI: begin
                        if (align_r == `AFR_ALIGN_RIGHT && hold_v_r) begin
                            rdata_nxt  = hold_r;
                            hold_v_nxt = 1'b0;
                        end else begin
                            rdata_nxt  = res_hi_r;
                            hold_nxt   = res_lo_r;
                            hold_v_nxt = (align_r == `AFR_ALIGN_LEFT);
                        end
                    end
                    `AFR_RES_LO: begin
                        if (align_r == `AFR_ALIGN_LEFT && hold_v_r) begin
                            rdata_nxt  = hold_r;
                            hold_v_nxt = 1'b0;
                        end else begin
                            rdata_nxt  = res_lo_r;
                            hold_nxt   = res_hi_r;
                            hold_v_nxt = (align_r == `AFR_ALIGN_RIGHT);
                        end
                    end
                    `AFR_TDR_HI:  rdata_nxt = tdr_r[15:8];
                    `AFR_TDR_LO:  rdata_nxt = tdr_r[7:0];
                    `AFR_UTH_HI:  rdata_nxt = uth_r[9:2];
                    `AFR_UTH_LO:  rdata_nxt = {6'h00, uth_r[1:0]};
                    `AFR_LTH_HI:  rdata_nxt = lth_r[9:2];
                    `AFR_LTH_LO:  rdata_nxt = {6'h00, lth_r[1:0]};
                    `AFR_AWS_HI:  rdata_nxt = {6'h00, aws_r[9:8]};
                    `AFR_AWS_LO:  rdata_nxt = aws_r[7:0];
                    `AFR_AWEN_HI: rdata_nxt = {6'h00, awen_r[9:8]};
                    `AFR_AWEN_LO: rdata_nxt = awen_r[7:0];
                    default:      rdata_nxt = 8'h00;
                endcase
            end
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            res_hi_r <= `AFR_RST_BYTE;
            res_lo_r <= `AFR_RST_BYTE;
            hold_r   <= `AFR_RST_BYTE;
            hold_v_r <= 1'b0;
            rdata_r  <= 8'h00;
        end else begin
            res_hi_r <= res_hi_nxt;
            res_lo_r <= res_lo_nxt;
            hold_r   <= hold_nxt;
            hold_v_r <= hold_v_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops

    assign bus_rdata      = rdata_r;
    assign conv_stop      = stop_r;
    assign irq            = irq_r;
    // wait wake follows the request; no halt wake exists
    assign wake_from_wait = irq_r;
    assign conv_on        = adon_r;
    assign conv_cont      = cont_r;
    assign conv_scan      = scan_r;
    assign conv_dbuf      = dbuf_r;
    assign conv_channel   = ch_r;
    assign schmitt_off    = tdr_r;

endmodule : afr_flag_result
`default_nettype wire

// ==== bench/afr_flag_result_sva.sv ====
// Port-level assertions for the flag/result block
`timescale 1ns/1ns
`default_nettype none

module afr_flag_result_sva (
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire logic [7:0]         bus_addr,
    input wire logic [7:0]         bus_wdata,
    input wire logic               bus_wr,
    input wire logic               bus_rd,
    input wire logic [7:0]         bus_rdata,
    input wire afr_pkg::afr_conv_s conv_in,
    input wire logic               seq_end,
    input wire logic               conv_stop,
    input wire logic               irq,
    input wire logic               wake_from_wait,
    input wire logic               conv_on,
    input wire logic               conv_cont,
    input wire logic               conv_scan,
    input wire logic               conv_dbuf,
    input wire logic [3:0]         conv_channel,
    input wire logic [15:0]        schmitt_off
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////
    // Wake request mirrors the interrupt; halt wake has no output at all
    property p_wake;
        wake_from_wait == irq;
    endproperty
    a_wake: assert property (p_wake) else $error("wake differs from irq");
    property p_tdr_hi;
        bus_wr && bus_addr == 8'h26 |=> schmitt_off[15:8] == $past(bus_wdata);
    endproperty
    a_tdr_hi: assert property (p_tdr_hi) else $error("trigger high");
    property p_tdr_lo;
        bus_wr && bus_addr == 8'h27 |=> schmitt_off[7:0] == $past(bus_wdata);
    endproperty
    a_tdr_lo: assert property (p_tdr_lo) else $error("trigger low");
    property p_scan_cfg;
        bus_wr && bus_addr == 8'h22 |=> conv_scan == $past(bus_wdata[1]);
    endproperty
    a_scan_cfg: assert property (p_scan_cfg) else $error("scan bit");
    property p_cont_cfg;
        bus_wr && bus_addr == 8'h21 |=>
            {conv_cont, conv_on} == $past(bus_wdata[1:0]);
    endproperty
    a_cont_cfg: assert property (p_cont_cfg) else $error("cont bits");
    // Stop only comes with a raised interrupt, right after a conversion
    property p_stop_irq;
        conv_stop |-> irq;
    endproperty
    a_stop_irq: assert property (p_stop_irq) else $error("stop no irq");
    property p_stop_cause;
        conv_stop |-> $past(conv_in.valid);
    endproperty
    a_stop_cause: assert property (p_stop_cause) else $error("stop cause");
    // Clearing all flags and enables drops the request next cycle
    property p_irq_clear;
        bus_wr && bus_addr == 8'h20 && bus_wdata == 8'h00
            && !conv_in.valid && !seq_end |=> !irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq stuck");
    // An enable write reaches the request one cycle later than a flag
    property p_irq_rise;
        $rose(irq) |-> $past(conv_in.valid || seq_end || bus_wr)
            || $past(bus_wr, 2);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq no cause");

    c_stop: cover property (conv_stop);
    c_irq: cover property ($rose(irq));
    c_tdr: cover property (bus_wr && bus_addr == 8'h26);
endmodule : afr_flag_result_sva

bind afr_flag_result afr_flag_result_sva u_sva (.*);

`default_nettype wire

// ==== bench/test_afr_flag_result.sv ====
// Self-checking bench for the flag/result block
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("CHECK FAILED at %0t: got %h expected %h", \
                 $time, got, exp); \
    end \
end

module test_afr_flag_result;
    logic               clk;
    logic               sys_rst;
    logic [7:0]         bus_addr;
    logic [7:0]         bus_wdata;
    logic               bus_wr;
    logic               bus_rd;
    logic [7:0]         bus_rdata;
    afr_pkg::afr_conv_s conv_in;
    logic               seq_end;
    logic               conv_stop;
    logic               irq;
    logic               wake_from_wait;
    logic               conv_on;
    logic               conv_cont;
    logic               conv_scan;
    logic               conv_dbuf;
    logic [3:0]         conv_channel;
    logic [15:0]        schmitt_off;
    int                 mismatches;
    int                 total_checks;
    int                 stops;

    afr_flag_result dut (.*);

    ////////////////////////////////////////////////////////////////////////
    // Clock and stop-pulse tally
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (conv_stop === 1'b1) stops++;
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus and converter drivers; a gap cycle keeps strobes single-assigned
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        `CHK(bus_rdata, e)
        @(posedge clk);
    endtask : rd
    task automatic conv(input logic [3:0] i, input logic [9:0] d);
        conv_in <= {1'b1, i, d};
        @(posedge clk);
        conv_in <= '0;
        @(posedge clk);
    endtask : conv
    task automatic seq();
        seq_end <= 1'b1;
        @(posedge clk);
        seq_end <= 1'b0;
        @(posedge clk);
    endtask : seq
    // Outputs looked at off the edge, once settled
    task automatic chk_out(input logic [15:0] g, input logic [15:0] e);
        #1;
        `CHK(g, e)
        @(posedge clk);
    endtask : chk_out
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    // Hang guard
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        give_verdict;
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        sys_rst = 1'b1;
        bus_addr = 8'h00;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        conv_in = '0;
        seq_end = 1'b0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        rd(8'h20, 8'h00);
        rd(8'h28, 8'hFF);
        rd(8'h2B, 8'h00);
        rd(8'h30, 8'h00);
        $display("test reset done");
        // Buffered run, window 0x010..0x200, watch slot 1
        wr(8'h21, 8'h03);
        wr(8'h23, 8'h80);
        wr(8'h22, 8'h08);
        wr(8'h28, 8'h80);
        wr(8'h29, 8'h00);
        wr(8'h2A, 8'h04);
        wr(8'h2F, 8'h02);
        wr(8'h20, 8'h20);
        chk_out(conv_dbuf, 1'b1);
        for (int i = 0; i < 10; i++)
            conv(i[3:0], (i == 1) ? 10'h300 : 10'h100);
        rd(8'h2D, 8'h02);
        rd(8'h20, 8'h20);
        seq();
        rd(8'h20, 8'hE0);
        chk_out(irq, 1'b1);
        chk_out({irq, wake_from_wait}, 16'h0003);
        rd(8'h02, 8'h03);
        conv(4'h1, 10'h155);
        rd(8'h03, 8'h55);
        // Double read of one slot must agree when nothing converts
        rd(8'h02, 8'h01);
        rd(8'h03, 8'h55);
        wr(8'h20, 8'hA0);
        rd(8'h20, 8'hA0);
        wr(8'h20, 8'h20);
        rd(8'h20, 8'h20);
        wr(8'h20, 8'h10);
        seq();
        rd(8'h20, 8'hD0);
        chk_out(irq, 1'b1);
        seq();
        rd(8'h23, 8'hC0);
        wr(8'h2D, 8'h00);
        wr(8'h20, 8'h30);
        conv(4'h1, 10'h300);
        rd(8'h20, 8'h70);
        chk_out(stops, 1);
        $display("test buffered done");
        // Scan, watch channel 3
        wr(8'h23, 8'h00);
        rd(8'h23, 8'h00);
        wr(8'h21, 8'h01);
        wr(8'h22, 8'h0A);
        wr(8'h2D, 8'h00);
        wr(8'h2F, 8'h08);
        wr(8'h20, 8'h00);
        chk_out({conv_on, conv_cont, conv_scan, conv_dbuf}, 16'h000A);
        conv(4'h3, 10'h005);
        rd(8'h2D, 8'h08);
        rd(8'h20, 8'h00);
        seq();
        rd(8'h20, 8'hC0);
        chk_out(irq, 1'b0);
        wr(8'h20, 8'h10);
        seq();
        rd(8'h20, 8'hD0);
        chk_out({irq, stops[14:0]}, 16'h8001);
        wr(8'h2D, 8'h00);
        wr(8'h20, 8'h30);
        conv(4'h3, 10'h3F0);
        rd(8'h20, 8'h70);
        chk_out({irq, stops[14:0]}, 16'h8002);
        wr(8'h20, 8'h20);
        seq();
        rd(8'h20, 8'hE0);
        chk_out(irq, 1'b1);
        $display("test scan done");
        // Alignment and pair coherency, single then continuous mode
        wr(8'h21, 8'h00);
        wr(8'h22, 8'h08);
        conv(4'h0, 10'h2A5);
        rd(8'h25, 8'hA5);
        conv(4'h0, 10'h15A);
        rd(8'h24, 8'h02);
        rd(8'h25, 8'h5A);
        rd(8'h24, 8'h01);
        wr(8'h22, 8'h00);
        wr(8'h21, 8'h02);
        conv(4'h0, 10'h15A);
        rd(8'h24, 8'h56);
        conv(4'h0, 10'h3FF);
        rd(8'h25, 8'h80);
        rd(8'h24, 8'hFF);
        rd(8'h25, 8'hC0);
        $display("test align done");
        // Trigger disables and channel field
        wr(8'h26, 8'hA5);
        wr(8'h27, 8'h3C);
        wr(8'h20, 8'h07);
        chk_out(schmitt_off, 16'hA53C);
        rd(8'h26, 8'hA5);
        chk_out(conv_channel, 4'h7);
        $display("test trigger done");
        give_verdict;
    end
endmodule : test_afr_flag_result

`default_nettype wire
